/* rtl/serial_adc_conversion_sequencer.sv */
// Serial control, track/hold timing, SAR sequencing and result shifter of an 8-input 10-bit converter
`timescale 1ns/10ps
`include "adc_seq_map.svh"

module serial_adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire logic     ce,
    input  wire logic     sclk_pin,
    input  wire logic     cs_n_pin,
    input  wire logic     din_pin,
    input  wire logic     shutdown_n,
    input  wire logic     comparator_pin,
    output logic          dout,
    output logic          dout_oe,
    output logic          conversion_strobe_out,
    output logic          strobe_oe,
    output channel_t      pos_channel,
    output channel_t      neg_channel,
    output logic          neg_to_common,
    output logic          tracking,
    output logic          hold_capacitor,
    output result_t       dac_code,
    output logic          unipolar_bipolar_flag,
    output logic [1:0]    power_mode,
    output logic          shutdown_active,
    output logic          converting
);
    // Pin synchronisers: stage one feeds only stage two
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       sclk_prev_q;
    logic       sclk_s;
    logic       cs_n_s;
    logic       din_s;
    logic       comp_s;
    logic       shutdown_n_n_s;
    logic       shutdown_n_meta_q;
    logic       sclk_rise;
    logic       sclk_fall;

    // Sync resets to idle levels: select high, so no false frame follows reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 4'h2;
            sync2_q <= 4'h2;
        end else if (ce) begin
            sync1_q <= {comparator_pin, din_pin, cs_n_pin, sclk_pin};
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shutdown_n_n_s <= 1'b1;
        end else if (ce) begin
            shutdown_n_n_s <= shutdown_n_meta_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shutdown_n_meta_q <= 1'b1;
        end else if (ce) begin
            shutdown_n_meta_q <= shutdown_n;
        end
    end

    assign sclk_s = sync2_q[0];
    assign cs_n_s = sync2_q[1];
    assign din_s  = sync2_q[2];
    assign comp_s = sync2_q[3];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else if (ce) begin
            sclk_prev_q <= sclk_s;
        end
    end

    // Serial clock times every step of the sequence except the result push and a shutdown abort
    assign sclk_rise = ce && sclk_s && !sclk_prev_q;
    assign sclk_fall = ce && !sclk_s && sclk_prev_q;

    // Channel code from the two low select bits and a polarity bit
    function automatic channel_t chan_of(input logic [2:0] sel, input logic odd);
        chan_of = {sel[1:0], odd};
    endfunction

    // Sequencer state
    seq_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [3:0] period_q;
    logic [7:0] ctrl_q;
    result_t    result_q;
    result_t    trial_q;
    logic       track_q;
    logic       hold_q;
    logic       strobe_q;
    logic       push_valid;
    logic       push_ready;
    logic       bits_done;
    logic       abort;
    logic       ctrl_take;
    logic       pop_valid;
    logic       pop_ready;
    result_t    pop_data;

    assign push_valid = (state_q == ST_PUSH);
    assign bits_done  = (bit_cnt_q == `CTRL_BITS);
    assign abort      = !shutdown_n_n_s;
    assign ctrl_take  = sclk_fall && state_q == ST_CONTROL && bits_done && !abort;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_WAIT_START;
        end else if (abort) begin
            state_q <= ST_WAIT_START;
        end else if (ce) begin
            unique case (state_q)
                ST_WAIT_START: begin
                    if (sclk_rise && !cs_n_s && din_s) begin
                        state_q <= ST_CONTROL;
                    end
                end
                ST_CONTROL: begin
                    if (sclk_fall && bits_done) begin
                        state_q <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    // Decisions on rises 2 to 11, push on rise 15
                    if (sclk_rise && period_q == `CONV_PERIODS - 4'h1) begin
                        state_q <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    // Full result queue stalls the next conversion
                    if (push_ready) begin
                        state_q <= ST_WAIT_START;
                    end
                end
            endcase
        end
    end

    // Control byte shift register, MSB first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q   <= `CTRL_RESET;
            bit_cnt_q <= 4'h0;
        end else if (abort) begin
            bit_cnt_q <= 4'h0;
        end else if (sclk_rise && !cs_n_s) begin
            if (state_q == ST_WAIT_START && din_s) begin
                shift_q   <= {7'h00, 1'b1};
                bit_cnt_q <= 4'h1;
            end else if (state_q == ST_CONTROL && !bits_done) begin
                shift_q   <= {shift_q[6:0], din_s};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end else if (state_q == ST_WAIT_START) begin
            bit_cnt_q <= 4'h0;
        end
    end

    // Latch the control byte once all eight bits are in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET;
        end else if (ctrl_take) begin
            ctrl_q <= shift_q;
        end
    end

    // Channel routing registered with the control byte
    channel_t pos_chan_q;
    channel_t neg_chan_q;
    logic     neg_common_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_chan_q   <= 3'h0;
            neg_chan_q   <= 3'h0;
            neg_common_q <= 1'b0;
        end else if (ctrl_take) begin
            pos_chan_q <= chan_of(shift_q[`FIELD_SEL_HI:`FIELD_SEL_LO], shift_q[`FIELD_SEL_HI]);
            if (shift_q[`FIELD_SINGLE_ENDED_DIFFERENTIAL_FLAG]) begin
                neg_chan_q   <= chan_of(shift_q[`FIELD_SEL_HI:`FIELD_SEL_LO], shift_q[`FIELD_SEL_HI]);
                neg_common_q <= 1'b1;
            end else begin
                neg_chan_q   <= chan_of(shift_q[`FIELD_SEL_HI:`FIELD_SEL_LO], !shift_q[`FIELD_SEL_HI]);
                neg_common_q <= 1'b0;
            end
        end
    end

    // Track after fifth bit, hold after eighth
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            track_q <= 1'b0;
            hold_q  <= 1'b0;
        end else if (abort) begin
            track_q <= 1'b0;
            hold_q  <= 1'b0;
        end else if (sclk_fall && state_q == ST_CONTROL) begin
            if (bit_cnt_q == `TRACK_AFTER_BIT) begin
                track_q <= 1'b1;
            end
            if (bits_done) begin
                track_q <= 1'b0;
                hold_q  <= 1'b1;
            end
        end else if (state_q == ST_PUSH) begin
            hold_q <= 1'b0;
        end
    end

    // Conversion period counter, one step per serial clock rise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            period_q <= 4'h0;
        end else if (state_q != ST_CONVERT || abort) begin
            period_q <= 4'h0;
        end else if (sclk_rise) begin
            period_q <= period_q + 4'h1;
        end
    end

    // Strobe rises in the period just ahead of the MSB decision
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_q <= 1'b0;
        end else if (abort) begin
            strobe_q <= 1'b0;
        end else if (sclk_rise) begin
            strobe_q <= (state_q == ST_CONVERT) && (period_q == 4'h0);
        end
    end

    // Successive approximation: keep or drop the trial bit each step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_q <= `RESULT_RESET;
            trial_q  <= `RESULT_RESET;
        end else if (abort) begin
            // A cut conversion clears the trial bit but leaves its partial code in result_q
            trial_q  <= `RESULT_RESET;
        end else if (sclk_fall && state_q == ST_CONTROL && bits_done) begin
            result_q <= `RESULT_MSB_ONLY;
            trial_q  <= `RESULT_MSB_ONLY;
        end else if (sclk_rise && state_q == ST_CONVERT && period_q >= `FIRST_DECISION - 4'h1
                     && period_q < `FIRST_DECISION + `RESULT_BITS - 4'h1) begin
            // Comparator high means input is above the trial level
            if (!comp_s) begin
                result_q <= (result_q & ~trial_q) | (trial_q >> 1);
            end else begin
                result_q <= result_q | (trial_q >> 1);
            end
            trial_q <= trial_q >> 1;
        end
    end

    result_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (result_q),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // Output shifter drains the queue only while selected
    result_t    out_shift_q;
    logic [3:0] out_left_q;
    logic       dout_q;

    assign pop_ready = sclk_rise && !cs_n_s && out_left_q == 4'h0 && state_q != ST_CONVERT;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_shift_q <= `RESULT_RESET;
            out_left_q  <= 4'h0;
            dout_q      <= 1'b0;
        end else if (abort) begin
            // Shutdown also stops a word in flight
            out_left_q <= 4'h0;
            dout_q     <= 1'b0;
        end else if (sclk_rise) begin
            if (pop_ready && pop_valid) begin
                dout_q      <= pop_data[9];
                out_shift_q <= {pop_data[8:0], 1'b0};
                out_left_q  <= `RESULT_BITS - 4'h1;
            end else if (out_left_q != 4'h0 && !cs_n_s) begin
                dout_q      <= out_shift_q[9];
                out_shift_q <= {out_shift_q[8:0], 1'b0};
                out_left_q  <= out_left_q - 4'h1;
            end else begin
                dout_q <= 1'b0;
            end
        end
    end

    // Routing outputs come straight from their flops
    assign pos_channel           = pos_chan_q;
    assign neg_channel           = neg_chan_q;
    assign neg_to_common         = neg_common_q;

    // Data and strobe outputs float with chip select high
    assign dout_oe               = !cs_n_s;
    assign strobe_oe             = !cs_n_s;
    assign dout                  = dout_q;
    assign conversion_strobe_out = strobe_q;
    assign tracking              = track_q;
    assign hold_capacitor        = hold_q;
    assign dac_code              = result_q;
    assign unipolar_bipolar_flag = ctrl_q[`FIELD_UNIPOLAR_BIPOLAR_FLAG];
    assign power_mode            = ctrl_q[`FIELD_PM_HI:`FIELD_PM_LO];
    assign shutdown_active       = !shutdown_n_n_s;
    assign converting            = state_q == ST_CONVERT;
endmodule

/* rtl/adc_seq_map.svh */
// Offsets, field positions, reset values and counts of the conversion sequencer
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

`define CTRL_BITS          4'h8
`define TRACK_AFTER_BIT    4'h5
`define HOLD_AFTER_BIT     4'h8
`define CONV_PERIODS       4'hF
`define STROBE_PERIOD      4'h1
`define FIRST_DECISION     4'h2
`define RESULT_BITS        4'hA
`define RESULT_MSB_ONLY    10'h200
`define RESULT_RESET       10'h000
`define CTRL_RESET         8'h00
`define FIELD_START        7
`define FIELD_SEL_HI       6
`define FIELD_SEL_LO       4
`define FIELD_UNIPOLAR_BIPOLAR_FLAG      3
`define FIELD_SINGLE_ENDED_DIFFERENTIAL_FLAG      2
`define FIELD_PM_HI        1
`define FIELD_PM_LO        0
`define FIFO_WIDTH         10
`define FIFO_DEPTH         16

`endif

/* rtl/adc_seq_pkg.sv */
// Types shared by the conversion sequencer
package adc_seq_pkg;
    typedef enum logic [2:0] {
        ST_WAIT_START = 3'b000,
        ST_CONTROL    = 3'b001,
        ST_CONVERT    = 3'b010,
        ST_PUSH       = 3'b011
    } seq_state_t;

    typedef logic [9:0] result_t;
    typedef logic [2:0] channel_t;
endpackage

/* rtl/result_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module result_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0]) || (wr_ptr_q[AW] == rd_ptr_q[AW]);
    assign out_valid = wr_ptr_q != rd_ptr_q;
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;
    assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule

/* bench/seq_checker_assertions.sv */
// Port-level checker for the conversion sequencer
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module seq_checker
    import adc_seq_pkg::*;
(
    input wire logic     clk,
    input wire logic     rst,
    input wire logic     sclk_pin,
    input wire logic     cs_n_pin,
    input wire logic     shutdown_n,
    input wire logic     dout,
    input wire logic     dout_oe,
    input wire logic     conversion_strobe_out,
    input wire logic     strobe_oe,
    input wire channel_t pos_channel,
    input wire channel_t neg_channel,
    input wire logic     neg_to_common,
    input wire logic     tracking,
    input wire logic     hold_capacitor,
    input wire result_t  dac_code,
    input wire logic     shutdown_active,
    input wire logic     converting
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Three samples cover the two-flop synchroniser
    a_oe_cs_high: assert property (cs_n_pin [*3] |=> !dout_oe && !strobe_oe)
        else $error("outputs enabled while deselected");
    a_din_ignored: assert property (cs_n_pin [*8] |=> !$rose(tracking))
        else $error("tracking began while deselected");
    a_strobe_width: assert property ($rose(conversion_strobe_out) |-> conversion_strobe_out [*6])
        else $error("strobe shorter than a serial period");
    a_strobe_ends: assert property ($rose(conversion_strobe_out) |-> ##[6:400] !conversion_strobe_out)
        else $error("strobe never dropped");
    a_strobe_in_conv: assert property ($rose(conversion_strobe_out) |-> converting && hold_capacitor)
        else $error("strobe outside conversion");
    a_hold_at_start: assert property ($rose(converting) |-> hold_capacitor && !tracking
                                      && dac_code == `RESULT_MSB_ONLY)
        else $error("conversion began without hold or first trial");
    a_se_mux: assert property (converting && neg_to_common |-> neg_channel == pos_channel)
        else $error("single-ended routing wrong");
    a_diff_pair: assert property (converting && !neg_to_common |-> pos_channel[2:1] == neg_channel[2:1]
                                  && pos_channel[0] != neg_channel[0])
        else $error("differential pair not adjacent");
    a_shutdown_abort: assert property (!shutdown_n [*3] |=> shutdown_active && !converting)
        else $error("shutdown did not abort");
    a_quiet_conv: assert property (converting |-> !dout)
        else $error("data out busy during conversion");
    a_dout_on_rise: assert property ($changed(dout) |-> $past(sclk_pin, 3) || $past(sclk_pin, 4)
                                     || $past(sclk_pin, 5))
        else $error("data out moved without a serial rise");

    c_strobe: cover property ($rose(conversion_strobe_out));
    c_se_conv: cover property ($rose(converting) && neg_to_common);
    c_diff_conv: cover property ($rose(converting) && !neg_to_common);
    c_shutdown: cover property ($rose(shutdown_active));
endmodule

bind serial_adc_conversion_sequencer seq_checker u_seq_checker (.*);

/* bench/host_serial_master.sv */
// Host serial master model for the converter's serial pins
`timescale 1ns/10ps
module host_serial_master (
    input  wire logic clk,
    input  wire logic dout,
    input  wire logic strobe,
    input  wire logic oe,
    output logic      sclk,
    output logic      cs_n,
    output logic      din
);
    logic smp_d;
    logic smp_s;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // Four clk low, four high: 50 percent duty; released lines read as floating
    task automatic cyc(input logic d);
        din = d;
        repeat (4) @(posedge clk);
        #1;
        smp_d = oe ? dout : 1'bz;
        smp_s = oe ? strobe : 1'bz;
        sclk = 1'b1;
        repeat (4) @(posedge clk);
        #1 sclk = 1'b0;
    endtask

    // Serial clock runs with select high, data line held high
    task automatic idle(input int n);
        repeat (n) cyc(1'b1);
    endtask

    task automatic frame(input logic [7:0] ctrl, input int lead,
                         output logic [27:0] dq, output logic [27:0] sq);
        @(posedge clk);
        #1 cs_n = 1'b0;
        repeat (lead) cyc(1'b0);
        for (int i = 7; i >= 0; i--) cyc(ctrl[i]);
        for (int j = 0; j < 28; j++) begin
            cyc(1'b0);
            dq = {dq[26:0], smp_d};
            sq = {sq[26:0], smp_s};
        end
        cs_n = 1'b1;
    endtask
endmodule

/* bench/tb_serial_adc_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module tb_serial_adc_conversion_sequencer;
    import adc_seq_pkg::*;
    logic        clk, rst, ce, sclk_pin, cs_n_pin, din_pin, shutdown_n, comparator_pin;
    logic        dout, dout_oe, conversion_strobe_out, strobe_oe, neg_to_common, tracking;
    logic        hold_capacitor, unipolar_bipolar_flag, shutdown_active, converting;
    logic [1:0]  power_mode;
    channel_t    pos_channel, neg_channel;
    result_t     dac_code, analog;
    logic [27:0] dq, sq;
    int          error_cnt, checks_done, cycles, conv_len, trk_len;
    int          exp_q[$];

    serial_adc_conversion_sequencer dut (.*);
    host_serial_master host (.clk(clk), .dout(dout), .strobe(conversion_strobe_out),
        .oe(dout_oe & strobe_oe), .sclk(sclk_pin), .cs_n(cs_n_pin), .din(din_pin));

    // Analog input held half a step above its code
    assign comparator_pin = (analog >= dac_code);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic int sar(int a);
        int r;
        r = 0;
        for (int i = 9; i >= 0; i--) begin
            if (a >= (r | (1 << i)))
                r = r | (1 << i);
        end
        return r;
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (conv_len >= 0 && converting)
            conv_len++;
        if (tracking)
            trk_len++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        logic [7:0] ctrl;
        logic [2:0] p;
        int a;
        rst = 1'b1;
        ce = 1'b1;
        shutdown_n = 1'b1;
        analog = 10'h155;
        void'($urandom(93585));
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        repeat (5) @(posedge clk);
        #1 host.idle(6);
        chk({tracking, converting, dout_oe, strobe_oe}, 4'h0);
        // Pin shutdown mid-conversion: no result may follow
        fork
            host.frame(8'hFF, 0, dq, sq);
            begin
                repeat (120) @(posedge clk);
                #1 shutdown_n = 1'b0;
                repeat (4) @(posedge clk);
                #1 chk({shutdown_active, converting}, 2'b10);
                shutdown_n = 1'b1;
            end
        join
        chk(dq, 28'h000_0000);
        for (int i = 0; i < 16; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom % 1024;
            analog = a[9:0];
            ctrl = {1'b1, i[2:0], 4'($urandom)};
            ctrl[2] = i[3];
            exp_q.push_back(sar(a));
            conv_len = 0;
            trk_len = 0;
            host.frame(ctrl, $urandom % 3, dq, sq);
            chk(dq, {16'h0000, 10'(exp_q.pop_front()), 2'b00});
            chk(sq, 28'h400_0000);
            chk(conv_len inside {[115:117]}, 1);
            chk(trk_len inside {[23:25]}, 1);
            p = {ctrl[5:4], ctrl[6]};
            chk({pos_channel, neg_channel, neg_to_common, unipolar_bipolar_flag, power_mode},
                {p, ctrl[2] ? p : {ctrl[5:4], ~ctrl[6]}, ctrl[2], ctrl[3], ctrl[1:0]});
            repeat (3) @(posedge clk);
            #1 chk({dout_oe, strobe_oe}, 2'b00);
        end
        close_out();
    end
endmodule
